// >>> hw/module_sideband.sv
// module end of the sideband link: select, reset, init mode, interrupt
`timescale 1ns/1ns
`include "sideband_regs.svh"

module module_sideband
#(
   parameter int unsigned RESET_MIN_CYC = `RESET_MIN_PULSE_CYC,
   parameter int unsigned INIT_CYC = `MGMT_INIT_CYC
)
(
   input wire logic sys_clk_i,          // module clock
   input wire logic rst_i,              // power-up reset, high
   sideband_if.device_mp link,          // sideband pins
   input wire logic bus_req_i,          // serial bus transaction seen
   input wire logic hp_enable_i,        // software enables high power
   input wire logic fault_i,            // fault or critical status level
   input wire logic irq_ack_i,          // software cleared interrupt cause
   output sideband_pkg::module_state_t state_o, // power state
   output logic bus_grant_o,            // bus transaction accepted
   output logic not_ready_o,            // not-ready flag in memory map
   output logic high_power_o,           // high power mode active
   output logic settings_default_o      // defaults loaded: one-cycle pulse after a pin reset, held high while rst_i is high
);
   import sideband_pkg::*;

   typedef struct packed
   {
      logic [1:0] sel_sync;
      logic [1:0] rst_sync;
      logic [1:0] init_sync;
      logic [`CNT_W-1:0] low_cnt;
      logic [`CNT_W-1:0] init_cnt;
      module_state_t st;
      logic not_ready;
      logic done_irq;
      logic irq_oe_n;
      logic grant;
      logic hp;
      logic dflt;
   } dev_t;

   dev_t s_r;
   dev_t s_nxt;
   logic sel_low;
   logic rst_low;
   logic init_high;

   // second stage only; the first stage feeds nothing else
   assign sel_low = ~s_r.sel_sync[1];
   assign rst_low = ~s_r.rst_sync[1];
   assign init_high = s_r.init_sync[1];

   // next-state logic
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.sel_sync = {s_r.sel_sync[0], link.module_select_n};
      s_nxt.rst_sync = {s_r.rst_sync[0], link.module_reset_n};
      // undriven pin already reads high through the wire pull-up
      s_nxt.init_sync = {s_r.init_sync[0], link.init_level};
      s_nxt.dflt = 1'b0;
      // bus traffic counts only while selected
      s_nxt.grant = bus_req_i & sel_low;
      // low-time counter; saturates at the threshold
      if (!rst_low)
      begin
         s_nxt.low_cnt = '0;
      end
      else if (s_r.low_cnt < RESET_MIN_CYC[`CNT_W-1:0])
      begin
         s_nxt.low_cnt = s_r.low_cnt + `CNT_W'(1);
      end
      // sticky done interrupt; a new completion beats the ack
      if (irq_ack_i)
      begin
         s_nxt.done_irq = 1'b0;
      end
      case (s_r.st)
         ST_RESET:
         begin
            // held here while the pin stays low, defaults restored
            s_nxt.not_ready = 1'b1;
            s_nxt.hp = 1'b0;
            s_nxt.done_irq = 1'b0;
            s_nxt.init_cnt = '0;
            if (!rst_low)
            begin
               s_nxt.st = ST_INIT;
            end
         end
         ST_INIT:
         begin
            s_nxt.init_cnt = s_r.init_cnt + `CNT_W'(1);
            if (s_r.init_cnt >= INIT_CYC[`CNT_W-1:0] - `CNT_W'(1))
            begin
               s_nxt.not_ready = 1'b0;
               s_nxt.done_irq = 1'b1;
               s_nxt.st = ST_LOW_POWER;
            end
         end
         ST_LOW_POWER:
         begin
            // hardware control skips the software enable
            if (!init_high || hp_enable_i)
            begin
               s_nxt.hp = 1'b1;
               s_nxt.st = ST_HIGH_POWER;
            end
         end
         ST_HIGH_POWER:
         begin
            s_nxt.hp = 1'b1;
         end
         default:
         begin
            s_nxt.st = ST_RESET;
         end
      endcase
      // a long enough low pulse restarts everything
      if (rst_low && s_r.low_cnt >= RESET_MIN_CYC[`CNT_W-1:0]
          && s_r.st != ST_RESET)
      begin
         s_nxt.st = ST_RESET;
         s_nxt.not_ready = 1'b1;
         s_nxt.hp = 1'b0;
         s_nxt.done_irq = 1'b0;
         s_nxt.dflt = 1'b1;
      end
      // open drain: enable low pulls the line low, never drives high
      s_nxt.irq_oe_n = ~(s_nxt.done_irq | fault_i);
   end

   // state register; power-up starts in reset so completion is posted
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         s_r <= '0;
         s_r.sel_sync <= 2'h3;
         s_r.rst_sync <= 2'h3;
         s_r.init_sync <= 2'h3;
         s_r.st <= ST_RESET;
         s_r.not_ready <= 1'b1;
         s_r.irq_oe_n <= 1'b1;
         s_r.dflt <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // pins and status
   assign link.presence_out = 1'b0;
   assign link.presence_oe_n = 1'b0;
   assign link.interrupt_out = 1'b0;
   assign link.interrupt_oe_n = s_r.irq_oe_n;
   assign state_o = s_r.st;
   assign bus_grant_o = s_r.grant;
   assign not_ready_o = s_r.not_ready;
   assign high_power_o = s_r.hp;
   assign settings_default_o = s_r.dflt;
endmodule // module_sideband

// >>> hw/sideband_regs.svh
// sideband timing constants and counter width shared by both ends
`ifndef SIDEBAND_REGS_SVH
`define SIDEBAND_REGS_SVH

// least low time of the module reset input, in ns
`define RESET_MIN_PULSE_NS 2000
// clock period in ns
`define CLK_PERIOD_NS 10
// least low time in clock cycles, rounded up
`define RESET_MIN_PULSE_CYC \
   ((`RESET_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// management interface start-up time after any reset, in cycles
`define MGMT_INIT_CYC 64
// width of the duration counters
`define CNT_W 16

`endif

// >>> hw/sideband_pkg.sv
// types shared by the module end and the host end of the sideband link
package sideband_pkg;
   typedef enum logic [1:0]
   {
      ST_RESET,
      ST_INIT,
      ST_LOW_POWER,
      ST_HIGH_POWER
   } module_state_t;

   typedef enum logic [1:0]
   {
      H_IDLE,
      H_RESETTING,
      H_WAIT_DONE,
      H_READY
   } host_state_t;
endpackage

// >>> hw/sideband_if.sv
// sideband pins between host and module
`timescale 1ns/1ns
interface sideband_if;
   logic module_select_n;
   logic module_reset_n;
   logic init_control_select;
   logic init_oe_n;
   logic presence_out;
   logic presence_oe_n;
   logic interrupt_out;
   logic interrupt_oe_n;
   logic presence_detect_n;
   logic interrupt_n;
   logic init_level;

   // wire levels: pulled up unless a driver's enable is low
   assign presence_detect_n = presence_oe_n ? 1'b1 : presence_out;
   assign interrupt_n = interrupt_oe_n ? 1'b1 : interrupt_out;
   assign init_level = init_oe_n ? 1'b1 : init_control_select;

   modport device_mp
   (
      input module_select_n,
      input module_reset_n,
      input init_level,
      output presence_out,
      output presence_oe_n,
      output interrupt_out,
      output interrupt_oe_n
   );

   modport host_mp
   (
      output module_select_n,
      output module_reset_n,
      output init_control_select,
      output init_oe_n,
      input presence_detect_n,
      input interrupt_n
   );
endinterface // sideband_if

// >>> hw/host_sideband.sv
// host end of the sideband link: select, reset pulse, init mode
`timescale 1ns/1ns
`include "sideband_regs.svh"

module host_sideband
#(
   parameter int unsigned PULSE_CYC = `RESET_MIN_PULSE_CYC + 2
)
(
   input wire logic sys_clk_i,        // host clock
   input wire logic rst_i,            // reset, high
   sideband_if.host_mp link,          // sideband pins
   input wire logic select_i,         // address this module on the bus
   input wire logic reset_req_i,      // one-cycle pulse: reset module
   input wire logic hw_init_i,        // init mode strap: 1 hardware control
   input wire logic status_not_ready_i, // not-ready read over the bus
   output sideband_pkg::host_state_t state_o, // host view
   output logic present_o,            // module present
   output logic irq_o,                // interrupt seen
   output logic status_valid_o,       // status bits may be trusted
   output logic status_read_o         // level: read status to find cause
);
   import sideband_pkg::*;

   typedef struct packed
   {
      logic [1:0] prs_sync;
      logic [1:0] irq_sync;
      logic [`CNT_W-1:0] cnt;
      host_state_t st;
      logic sel_n;
      logic rst_n;
      logic init_hw;
      logic valid;
      logic rd;
   } host_t;

   host_t s_r;
   host_t s_nxt;
   logic irq_low;

   assign irq_low = ~s_r.irq_sync[1];

   // next-state logic
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.prs_sync = {s_r.prs_sync[0], link.presence_detect_n};
      s_nxt.irq_sync = {s_r.irq_sync[0], link.interrupt_n};
      // one select line per module, driven only for this one
      s_nxt.sel_n = ~select_i;
      s_nxt.rd = irq_low;
      // mode strap caught only before the first ready, then held
      if (s_r.st == H_IDLE && !s_r.valid)
      begin
         s_nxt.init_hw = hw_init_i;
      end
      case (s_r.st)
         H_IDLE:
         begin
            s_nxt.rst_n = 1'b1;
            if (reset_req_i)
            begin
               s_nxt.rst_n = 1'b0;
               s_nxt.cnt = '0;
               s_nxt.valid = 1'b0;
               s_nxt.st = H_RESETTING;
            end
            else if (irq_low && !status_not_ready_i)
            begin
               s_nxt.st = H_READY;
               s_nxt.valid = 1'b1;
            end
         end
         H_RESETTING:
         begin
            s_nxt.cnt = s_r.cnt + `CNT_W'(1);
            if (s_r.cnt >= PULSE_CYC[`CNT_W-1:0])
            begin
               s_nxt.rst_n = 1'b1;
               s_nxt.st = H_WAIT_DONE;
            end
         end
         H_WAIT_DONE:
         begin
            // status ignored until completion interrupt with flag clear
            if (irq_low && !status_not_ready_i)
            begin
               s_nxt.valid = 1'b1;
               s_nxt.st = H_READY;
            end
         end
         H_READY:
         begin
            if (reset_req_i)
            begin
               s_nxt.rst_n = 1'b0;
               s_nxt.cnt = '0;
               s_nxt.valid = 1'b0;
               s_nxt.st = H_RESETTING;
            end
         end
         default:
         begin
            s_nxt.st = H_IDLE;
         end
      endcase
   end

   // init mode followed every cycle while idle before the first ready, then held fixed
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         s_r <= '0;
         s_r.prs_sync <= 2'h3;
         s_r.irq_sync <= 2'h3;
         s_r.sel_n <= 1'b1;
         s_r.rst_n <= 1'b1;
         s_r.st <= H_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign link.module_select_n = s_r.sel_n;
   assign link.module_reset_n = s_r.rst_n;
   assign link.init_control_select = 1'b0;
   assign link.init_oe_n = ~s_r.init_hw;
   assign state_o = s_r.st;
   assign present_o = ~s_r.prs_sync[1];
   assign irq_o = irq_low;
   assign status_valid_o = s_r.valid;
   assign status_read_o = s_r.rd;
endmodule // host_sideband

// >>> sim/sideband_checker.sv
// assertions on the sideband pins between host end and module end
`timescale 1ns/1ns
module sideband_checker
(
   input wire logic sys_clk_i, // clock
   input wire logic rst_i, // reset, high
   input wire logic module_reset_n, // module reset wire
   input wire logic presence_out, // presence drive value
   input wire logic presence_oe_n, // presence enable, low drives
   input wire logic presence_detect_n, // presence wire
   input wire logic interrupt_out, // interrupt drive value
   input wire logic interrupt_oe_n, // interrupt enable, low drives
   input wire logic interrupt_n, // interrupt wire
   input wire logic init_oe_n, // init enable, low drives
   input wire logic init_level // init wire
);
   default clocking cb
      @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   // host pulse is 11 cycles; split so no repetition unrolls past 8
   sequence seq_pulse;
      !module_reset_n[*8] ##1 !module_reset_n[*3] ##1 module_reset_n;
   endsequence
   // interrupt stays released through sync and start-up, then posts
   sequence seq_done;
      interrupt_n[*6] ##[1:8] !interrupt_n;
   endsequence

   chk_presence_drive: assert property (!presence_oe_n && !presence_out)
      else $error("presence line not tied low");
   chk_presence_seen: assert property (!presence_detect_n)
      else $error("presence wire reads high");
   chk_irq_never_high: assert property (!interrupt_oe_n |-> !interrupt_out)
      else $error("interrupt driven high");
   chk_init_pulled: assert property (init_oe_n |-> init_level)
      else $error("undriven init select not high");
   chk_pulse_len: assert property ($fell(module_reset_n) |-> seq_pulse)
      else $error("reset pulse length wrong");
   chk_reset_quiet: assert property (!module_reset_n[*8] |-> ##2 interrupt_n)
      else $error("interrupt held during reset");
   chk_done_post: assert property ($rose(module_reset_n) |-> seq_done)
      else $error("reset completion interrupt timing wrong");
   chk_power_done: assert property ($fell(rst_i) |-> ##[1:20] !interrupt_n)
      else $error("no completion interrupt after power-up");
endmodule // sideband_checker

// >>> sim/tb_top.sv
// self-checking bench joining the host end and the module end
`timescale 1ns/1ns
module tb_top;
   import sideband_pkg::*;
   logic sys_clk_i, rst_i, bus_req_i, hp_enable_i, fault_i, irq_ack_i;
   logic select_i, reset_req_i, hw_init_i;
   logic bus_grant_o, not_ready_o, high_power_o;
   logic present_o, irq_o;
   module_state_t m_state;
   host_state_t h_state;
   logic status_valid_o, status_read_o, settings_default_o;
   logic rst_d, dflt_seen;
   logic [12:0] q[$];
   int failures = 0;
   int num_checks = 0;
   event obs;
   sideband_if sb();

   module_sideband #(.RESET_MIN_CYC(4), .INIT_CYC(4)) module_sideband_i
   (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(sb.device_mp),
      .bus_req_i(bus_req_i), .hp_enable_i(hp_enable_i),
      .fault_i(fault_i), .irq_ack_i(irq_ack_i), .state_o(m_state),
      .bus_grant_o(bus_grant_o), .not_ready_o(not_ready_o),
      .high_power_o(high_power_o),
      .settings_default_o(settings_default_o)
   );
   // bus read of not-ready is modelled by feeding the flag straight back
   host_sideband #(.PULSE_CYC(10)) host_sideband_i
   (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(sb.host_mp),
      .select_i(select_i), .reset_req_i(reset_req_i),
      .hw_init_i(hw_init_i), .status_not_ready_i(not_ready_o),
      .state_o(h_state), .present_o(present_o), .irq_o(irq_o),
      .status_valid_o(status_valid_o), .status_read_o(status_read_o)
   );
   sideband_checker sideband_checker_i
   (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .module_reset_n(sb.module_reset_n), .presence_out(sb.presence_out),
      .presence_oe_n(sb.presence_oe_n),
      .presence_detect_n(sb.presence_detect_n),
      .interrupt_out(sb.interrupt_out), .interrupt_oe_n(sb.interrupt_oe_n),
      .interrupt_n(sb.interrupt_n), .init_oe_n(sb.init_oe_n),
      .init_level(sb.init_level)
   );

   task check(input logic [12:0] seen, input logic [12:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   // host irq view is the inverse of the wire; presence always seen
   // host must read status while the wire is low, three cycles behind it
   task note_exp(input logic gr, nr, hp, irq, input module_state_t st,
      input host_state_t hs, input logic vd, df);
      q.push_back({gr, nr, hp, irq, ~irq, 1'b1, st, hs, vd, ~irq, df});
      ->obs;
   endtask

   // defaults pulse seen outside the bench reset window only
   always @(posedge sys_clk_i)
   begin
      rst_d <= rst_i;
      if (rst_i)
         dflt_seen <= 1'b0;
      else if (settings_default_o && !rst_d)
         dflt_seen <= 1'b1;
   end

   task cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask

   task wrap_up;
      if (failures == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // clock at 100 MHz
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   // outputs are settled when a note arrives, so compare at once
   always @(obs)
      check({bus_grant_o, not_ready_o, high_power_o, sb.interrupt_n, irq_o,
         present_o, m_state, h_state, status_valid_o, status_read_o,
         dflt_seen}, q.pop_front());

   // whole run is about 200 cycles; the limit leaves wide margin
   initial
   begin
      #20000;
      failures++;
      wrap_up;
   end

   // main sequence, inputs change at the falling edge
   initial
   begin
      {rst_i, bus_req_i, hp_enable_i, fault_i, irq_ack_i} = 5'h10;
      {select_i, reset_req_i, hw_init_i} = 3'h0;
      void'($urandom(32));
      cyc(20);
      rst_i = 1'b0;
      cyc(3);
      note_exp(0, 1, 0, 1, ST_INIT, H_IDLE, 0, 0);
      cyc(20);
      note_exp(0, 0, 0, 0, ST_LOW_POWER, H_READY, 1, 0);
      hp_enable_i = 1'b1;
      cyc(1);
      hp_enable_i = 1'b0;
      cyc(5);
      note_exp(0, 0, 1, 0, ST_HIGH_POWER, H_READY, 1, 0);
      irq_ack_i = 1'b1;
      cyc(1);
      irq_ack_i = 1'b0;
      cyc(5);
      note_exp(0, 0, 1, 1, ST_HIGH_POWER, H_READY, 1, 0);
      fault_i = 1'b1;
      cyc(5);
      note_exp(0, 0, 1, 0, ST_HIGH_POWER, H_READY, 1, 0);
      fault_i = 1'b0;
      cyc(5);
      note_exp(0, 0, 1, 1, ST_HIGH_POWER, H_READY, 1, 0);
      // random select and bus traffic: grant only while selected
      repeat (8)
      begin
         select_i = 1'($urandom);
         bus_req_i = 1'($urandom);
         cyc(6);
         note_exp(select_i & bus_req_i, 0, 1, 1, ST_HIGH_POWER, H_READY,
            1, 0);
      end
      {select_i, bus_req_i} = 2'h0;
      // host pulse must bring back low power defaults and repost done
      reset_req_i = 1'b1;
      cyc(1);
      reset_req_i = 1'b0;
      cyc(40);
      note_exp(0, 0, 0, 0, ST_LOW_POWER, H_READY, 1, 1);
      // init mode is only changed under reset
      rst_i = 1'b1;
      hw_init_i = 1'b1;
      cyc(20);
      rst_i = 1'b0;
      cyc(20);
      note_exp(0, 0, 1, 0, ST_HIGH_POWER, H_READY, 1, 0);
      cyc(1);
      wrap_up;
   end
endmodule // tb_top
